// ---- dv/tb_top.sv ----
// Self-checking testbench for the two-channel compare match timer.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin bad_count++; $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module tb_top;
  import cmt_pkg::*;
  logic        hclk       = 1'b0;
  logic        hresetn    = 1'b0;
  logic        hsel       = 1'b0;
  logic        hwrite     = 1'b0;
  logic        standby    = 1'b0;
  logic        manual_rst = 1'b0;
  logic [31:0] haddr      = 32'h0;
  logic [31:0] hwdata     = 32'h0;
  logic [1:0]  htrans     = 2'h0;
  logic [2:0]  hsize      = 3'h2;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [1:0]  irq;
  logic [31:0] rdv;
  int          bad_count  = 0;
  int          compares   = 0;
  int          cyc        = 0;
  int          m[0:63];
  int          armed[2];
  int          cor;

  compare_match_timer i_compare_match_timer (
    .hclk              (hclk),
    .hresetn           (hresetn),
    .hsel              (hsel),
    .haddr             (haddr),
    .htrans            (htrans),
    .hwrite            (hwrite),
    .hsize             (hsize),
    .hwdata            (hwdata),
    .hready            (hreadyout),
    .hrdata            (hrdata),
    .hreadyout         (hreadyout),
    .hresp             (hresp),
    .standby           (standby),
    .manual_rst        (manual_rst),
    .match_irq_request (irq)
  );

  always #5 hclk = ~hclk;

  // A hung handshake would otherwise stall the run forever.
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      bad_count++;
      end_of_test();
    end
  end

  // --------------------------------------------------------------------------
  // Bus tasks and reference model
  // --------------------------------------------------------------------------
  task automatic bus(input logic [5:0] idx, input logic wr, input logic [15:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {16'h0, d};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rdv = hrdata;
  endtask : bus

  task automatic mwr(input int idx, input int d);
    int ch;
    int k;
    ch = (idx - 2) / 6;
    k  = (idx - 2) % 6;
    bus(6'(idx), 1'b1, 16'(d));
    if (idx == 0)
      m[0] = d & 3;
    else if (idx >= 2 && idx <= 'hC && idx % 2 == 0)
    begin
      // A flag write of zero only counts once a read has shown the flag set.
      if (k == 0)
      begin
        m[idx]    = (d & 'h43) | (m[idx] & 'h80 & ((d & 'h80) | (armed[ch] ? 0 : 'h80)));
        armed[ch] = 0;
      end
      else
        m[idx] = d & 'hFFFF;
    end
  endtask : mwr

  task automatic chk(input int idx);
    bus(6'(idx), 1'b0, 16'h0);
    `CHK($sformatf("reg %0h", idx), 32'(m[idx]), rdv)
    if ((idx == 2 || idx == 8) && rdv[7] === 1'b1)
      armed[(idx - 2) / 6] = 1;
  endtask : chk

  task automatic chk_irq();
    for (int ch = 0; ch < 2; ch++)
      `CHK("irq", 1'((m[2 + 6 * ch] >> 7) & (m[2 + 6 * ch] >> 6)), irq[ch])
  endtask : chk_irq

  task automatic tick(input int ch, input int t);
    repeat (t)
      if (m[4 + 6 * ch] == m[6 + 6 * ch])
      begin
        m[4 + 6 * ch] = 0;
        m[2 + 6 * ch] |= 'h80;
      end
      else
        m[4 + 6 * ch] = (m[4 + 6 * ch] + 1) & 'hFFFF;
  endtask : tick

  task automatic reset_model();
    m        = '{default: 0};
    m[6]     = 'hFFFF;
    m[12]    = 'hFFFF;
    armed[0] = 0;
    armed[1] = 0;
  endtask : reset_model

  task automatic chk_all();
    for (int i = 0; i < 8; i++)
      chk(i < 7 ? 2 * i : 'h3F);
    chk_irq();
  endtask : chk_all

  task automatic end_of_test();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_of_test

  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial
  begin
    void'($urandom(3));
    reset_model();
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk_all();
    mwr('h3F, $urandom);
    chk('h3F);
    for (int c = 0; c < 4; c++)
    begin
      for (int ch = 0; ch < 2; ch++)
      begin
        cor = $urandom_range(40, 3);
        mwr(6 + 6 * ch, cor);
        mwr(4 + 6 * ch, $urandom_range(cor, 0));
        // A flag of one is written on purpose and must not stick; reserved bits are written as zero.
        mwr(2 + 6 * ch, 'h0080 | ((ch == c % 2) << 6) | (ch ? 3 - c : c));
      end
      // Run is set and cleared exactly 1024 clocks apart, a whole number of ticks.
      mwr(0, 3);
      repeat (1022) @(posedge hclk);
      mwr(0, 0);
      for (int ch = 0; ch < 2; ch++)
        tick(ch, 1024 >> (3 + 2 * (m[2 + 6 * ch] & 3)));
      for (int ch = 0; ch < 2; ch++)
      begin
        chk(4 + 6 * ch);
        chk_irq();
        mwr(2 + 6 * ch, m[2 + 6 * ch] & 'h43);
        chk(2 + 6 * ch);
        mwr(2 + 6 * ch, m[2 + 6 * ch] & 'h43);
        chk(2 + 6 * ch);
        chk_irq();
      end
    end
    mwr(2, 'h41);
    manual_rst <= 1'b1;
    @(posedge hclk);
    manual_rst <= 1'b0;
    @(posedge hclk);
    chk_all();
    // A prescaler restart puts the first divide-by-eight tick on the eighth edge after it,
    // which is the edge that commits the counter write below; the match clear must win.
    mwr(6, 5);
    mwr(4, 5);
    mwr(2, 'h40);
    manual_rst <= 1'b1;
    @(posedge hclk);
    manual_rst <= 1'b0;
    mwr(0, 1);
    repeat (4) @(posedge hclk);
    bus(6'h04, 1'b1, 16'h1234);
    tick(0, 1);
    mwr(0, 0);
    chk_all();
    mwr(2, 'hC0);
    chk(2);
    mwr(0, 3);
    standby <= 1'b1;
    @(posedge hclk);
    standby <= 1'b0;
    @(posedge hclk);
    reset_model();
    chk_all();
    end_of_test();
  end
endmodule : tb_top

// ---- rtl/cmt_defs.svh ----
// Constants of the two-channel compare match interval timer.
`ifndef CMT_DEFS_SVH
`define CMT_DEFS_SVH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define IDX_RUN     6'h00
`define IDX_CSR0    6'h02
`define IDX_CNT0    6'h04
`define IDX_COR0    6'h06
`define IDX_STRIDE  6'h06

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define FLAG_BIT    7
`define IE_BIT      6
`define CKS_HI      1
`define CKS_LO      0
`define RUN_RST     2'h0
`define CNT_RST     16'h0000
`define COR_RST     16'hFFFF

// ----------------------------------------------------------------------------
// Prescaler taps, one tick every 8, 32, 128 or 512 system clocks
// ----------------------------------------------------------------------------
`define PRESC_W     9
`define MASK_D8     9'h007
`define MASK_D32    9'h01F
`define MASK_D128   9'h07F
`define MASK_D512   9'h1FF

`endif

// ---- rtl/cmt_pkg.sv ----
// Types shared by the compare match timer.
package cmt_pkg;
  `include "cmt_defs.svh"

  typedef enum logic [1:0] {
    CKS_D8   = 2'h0,
    CKS_D32  = 2'h1,
    CKS_D128 = 2'h2,
    CKS_D512 = 2'h3
  } cks_e;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'h0,
    BUS_RD   = 2'h1
  } bus_e;

  typedef struct packed {
    logic [1:0]         run;
    logic [1:0]         flag;
    logic [1:0]         ie;
    logic [1:0][1:0]    cks;
    logic [1:0][15:0]   cnt;
    logic [1:0][15:0]   cor;
    logic [1:0]         seen;
    logic [1:0]         irq;
    logic [`PRESC_W-1:0] presc;
    bus_e               bus;
    logic               wr_pend;
    logic [5:0]         widx;
    logic [5:0]         ridx;
    logic               hreadyout_r;
    logic [15:0]        hrdata_r;
  } state_s;
endpackage : cmt_pkg

// ---- rtl/compare_match_timer.sv ----
// Two-channel compare match interval timer with an AHB-Lite register slave.
//
// Added by the designer: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
module compare_match_timer
  import cmt_pkg::*;
(
  // Clock and power-on reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Power management
  input  wire logic        standby,
  input  wire logic        manual_rst,
  // Interrupt requests
  output logic      [1:0]  match_irq_request
);

  // --------------------------------------------------------------------------
  // State and helpers
  // --------------------------------------------------------------------------
  state_s q;
  state_s n;

  logic       accept;
  logic       wr_now;
  logic [1:0] tick;
  logic [1:0] match;
  logic [1:0] wr_csr;
  logic [1:0] wr_cnt;
  logic [1:0] wr_cor;
  logic       wr_run;
  logic [5:0] aidx;

  function automatic logic [`PRESC_W-1:0] div_mask(input logic [1:0] sel);
    logic [`PRESC_W-1:0] m;
    m = `MASK_D8;
    case (cks_e'(sel))
      CKS_D8:   m = `MASK_D8;
      CKS_D32:  m = `MASK_D32;
      CKS_D128: m = `MASK_D128;
      CKS_D512: m = `MASK_D512;
      default:  m = `MASK_D8;
    endcase
    return m;
  endfunction : div_mask

  // Reserved control/status positions are simply driven as zero.
  function automatic logic [15:0] csr_view(input state_s s, input int c);
    logic [15:0] v;
    v             = 16'h0000;
    v[`FLAG_BIT]  = s.flag[c];
    v[`IE_BIT]    = s.ie[c];
    v[`CKS_HI:`CKS_LO] = s.cks[c];
    return v;
  endfunction : csr_view

  function automatic logic [15:0] read_mux(input state_s s, input logic [5:0] idx);
    logic [15:0] v;
    v = 16'h0000;
    if (idx == `IDX_RUN)
      v = {14'h0000, s.run};
    for (int c = 0; c < 2; c++)
    begin
      if (idx == 6'(`IDX_CSR0 + `IDX_STRIDE * c))
        v = csr_view(s, c);
      if (idx == 6'(`IDX_CNT0 + `IDX_STRIDE * c))
        v = s.cnt[c];
      if (idx == 6'(`IDX_COR0 + `IDX_STRIDE * c))
        v = s.cor[c];
    end
    return v;
  endfunction : read_mux

  // --------------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------------
  // Writes finish with no wait state; a write's data phase always ends on the
  // next edge because hreadyout is only pulled low for reads.
  assign accept = hsel && htrans[1] && hready;
  assign wr_now = q.wr_pend && q.hreadyout_r;
  assign aidx   = haddr[7:2];
  assign wr_run = wr_now && (q.widx == `IDX_RUN);

  for (genvar c = 0; c < 2; c++)
  begin : g_ch
    // Each channel taps the shared prescaler through its own mask.
    assign tick[c]   = (q.presc & div_mask(q.cks[c])) == div_mask(q.cks[c]);
    assign match[c]  = tick[c] && q.run[c] && (q.cnt[c] == q.cor[c]);
    assign wr_csr[c] = wr_now && (q.widx == 6'(`IDX_CSR0 + `IDX_STRIDE * c));
    assign wr_cnt[c] = wr_now && (q.widx == 6'(`IDX_CNT0 + `IDX_STRIDE * c));
    assign wr_cor[c] = wr_now && (q.widx == 6'(`IDX_COR0 + `IDX_STRIDE * c));
  end

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb
  begin
    n = q;

    // Manual reset restarts the prescaler phase and nothing else.
    n.presc = manual_rst ? '0 : q.presc + `PRESC_W'(1);

    if (wr_run)
      n.run = hwdata[1:0];

    for (int c = 0; c < 2; c++)
    begin
      if (q.run[c] && tick[c])
      begin
        if (match[c])
          n.cnt[c] = `CNT_RST;
        else
          n.cnt[c] = q.cnt[c] + 16'h0001;
      end
      // A write beats an increment but loses to a match clear.
      if (wr_cnt[c] && !match[c])
        n.cnt[c] = hwdata[15:0];
      if (wr_cor[c])
        n.cor[c] = hwdata[15:0];
      if (wr_csr[c])
      begin
        n.ie[c]  = hwdata[`IE_BIT];
        n.cks[c] = hwdata[`CKS_HI:`CKS_LO];
        if (!hwdata[`FLAG_BIT] && q.seen[c])
          n.flag[c] = 1'b0;
        n.seen[c] = 1'b0;
      end
      // Setting wins over a clear in the same cycle.
      if (match[c])
        n.flag[c] = 1'b1;
    end

    // Bus sequencing: reads take one wait state so the data always reflects
    // a write that finished on the edge the read was accepted.
    n.hreadyout_r = 1'b1;
    if (wr_now)
      n.wr_pend = 1'b0;
    case (q.bus)
      BUS_IDLE:
      begin
        if (accept && hwrite)
        begin
          n.wr_pend = 1'b1;
          n.widx    = aidx;
        end
        else if (accept)
        begin
          n.bus         = BUS_RD;
          n.ridx        = aidx;
          n.hreadyout_r = 1'b0;
        end
      end
      BUS_RD:
      begin
        n.bus      = BUS_IDLE;
        n.hrdata_r = read_mux(q, q.ridx);
        for (int c = 0; c < 2; c++)
        begin
          if (q.ridx == 6'(`IDX_CSR0 + `IDX_STRIDE * c) && q.flag[c])
            n.seen[c] = 1'b1;
        end
      end
      default:
      begin
        n.bus = BUS_IDLE;
      end
    endcase

    // Standby puts every timer register but the prescaler back to its power-on value.
    if (standby)
    begin
      n.run  = `RUN_RST;
      n.flag = 2'h0;
      n.ie   = 2'h0;
      n.cks  = {2{CKS_D8}};
      n.seen = 2'h0;
      n.cnt  = {2{`CNT_RST}};
      n.cor  = {2{`COR_RST}};
    end

    n.irq = n.flag & n.ie;
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      q             <= '0;
      q.cor         <= {2{`COR_RST}};
      q.hreadyout_r <= 1'b1;
    end
    else
    begin
      q <= n;
    end
  end

  assign hrdata            = {16'h0000, q.hrdata_r};
  assign hreadyout         = q.hreadyout_r;
  assign hresp             = 1'b0;
  assign match_irq_request = q.irq;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_flag_seen;
    q.bus == BUS_RD && q.ridx == `IDX_CSR0 && q.flag[0];
  endsequence

  sequence s_d8_tick;
    tick[0] && q.cks[0] == CKS_D8 && !manual_rst;
  endsequence

  a_standby_clears_csr: assert property (
    standby |=> q.flag == 2'h0 && q.ie == 2'h0 && q.cks == 4'h0 && q.run == 2'h0)
    else $error("standby did not clear control state");

  a_reserved_reads_zero: assert property (
    q.bus == BUS_RD && q.ridx == `IDX_CSR0 |=> hrdata[15:8] == 8'h00 && hrdata[5:2] == 4'h0)
    else $error("reserved control bits read nonzero");

  a_match_sets_flag: assert property (
    match[0] && !standby |=> q.flag[0] && q.cnt[0] == 16'h0000)
    else $error("match did not set flag and clear counter");

  a_flag_clear_needs_read: assert property (
    $fell(q.flag[0]) && !$past(standby) |-> $past(q.seen[0]))
    else $error("flag cleared without a prior read of one");

  a_flag_read_arms: assert property (
    s_flag_seen ##1 1'b1 |-> hrdata[`FLAG_BIT] && hreadyout)
    else $error("set flag not returned by read");

  a_count_increments: assert property (
    q.run[0] && tick[0] && !match[0] && !wr_cnt[0] && !standby |=> q.cnt[0] == $past(q.cnt[0]) + 16'h0001)
    else $error("counter did not increment on tick");

  a_count_holds: assert property (
    !q.run[0] && !wr_cnt[0] && !standby |=> $stable(q.cnt[0]))
    else $error("halted counter moved");

  // A prescaler restart inside the window moves the next tick, so such windows are not judged.
  a_d8_spacing: assert property (
    s_d8_tick ##1 (!tick[0] && !manual_rst)[*7] |-> ##1 (tick[0] || q.cks[0] != CKS_D8))
    else $error("divide by eight tick spacing wrong");

  a_clear_beats_write: assert property (
    match[0] && wr_cnt[0] && !standby |=> q.cnt[0] == 16'h0000)
    else $error("counter write beat a match clear");

  a_irq_on_match: assert property (
    match[0] && q.ie[0] && !standby |=> match_irq_request[0] [*2])
    else $error("enabled match raised no interrupt");

  a_cor_standby: assert property (
    standby |=> q.cor[0] == 16'hFFFF && q.cor[1] == 16'hFFFF)
    else $error("compare constant not restored by standby");

  // --------------------------------------------------------------------------
  // Channel one, the software write paths, and further channel zero, manual reset and standby checks
  // --------------------------------------------------------------------------
  sequence s_flag_seen1;
    q.bus == BUS_RD && q.ridx == 6'(`IDX_CSR0 + `IDX_STRIDE) && q.flag[1];
  endsequence

  a_ch1_match_flag: assert property (
    match[1] && !standby |=> q.flag[1] && q.cnt[1] == `CNT_RST)
    else $error("channel one match did not set flag and clear counter");

  a_ch1_reserved_zero: assert property (
    q.bus == BUS_RD && q.ridx == 6'(`IDX_CSR0 + `IDX_STRIDE) |=> hrdata[15:8] == 8'h00 && hrdata[5:2] == 4'h0)
    else $error("channel one reserved control bits read nonzero");

  a_ch1_flag_read: assert property (
    s_flag_seen1 ##1 1'b1 |-> hrdata[`FLAG_BIT] && hreadyout)
    else $error("channel one set flag not returned by read");

  a_ch1_flag_clear: assert property (
    $fell(q.flag[1]) && !$past(standby) |-> $past(q.seen[1]))
    else $error("channel one flag cleared without a prior read of one");

  a_ch1_count_inc: assert property (
    q.run[1] && tick[1] && !match[1] && !wr_cnt[1] && !standby |=> q.cnt[1] == $past(q.cnt[1]) + 16'h0001)
    else $error("channel one counter did not increment on tick");

  a_ch1_count_hold: assert property (
    !q.run[1] && !wr_cnt[1] && !standby |=> $stable(q.cnt[1]))
    else $error("channel one halted counter moved");

  a_ch1_clear_wins: assert property (
    match[1] && wr_cnt[1] && !standby |=> q.cnt[1] == `CNT_RST)
    else $error("channel one counter write beat a match clear");

  a_ch1_irq_match: assert property (
    match[1] && q.ie[1] && !standby |=> match_irq_request[1] [*2])
    else $error("channel one enabled match raised no interrupt");

  a_flag_write_one: assert property (
    wr_csr[0] && hwdata[`FLAG_BIT] && q.flag[0] && !standby |=> q.flag[0])
    else $error("writing one to the flag cleared it");

  a_flag_needs_match: assert property (
    $rose(q.flag[0]) |-> $past(match[0]))
    else $error("flag set without a compare match");

  a_run_write_lands: assert property (
    wr_run && !standby |=> q.run == $past(hwdata[1:0]))
    else $error("run register write did not land");

  a_cnt_write_lands: assert property (
    wr_cnt[0] && !match[0] && !standby |=> q.cnt[0] == $past(hwdata[15:0]))
    else $error("counter write did not land");

  a_idle_count_hold: assert property (
    q.run[0] && !tick[0] && !wr_cnt[0] && !standby |=> $stable(q.cnt[0]))
    else $error("running counter moved between ticks");

  a_manual_keeps_csr: assert property (
    manual_rst && !standby && !wr_csr[0] && !match[0] |=> $stable(q.flag[0]) && $stable(q.ie[0]) && $stable(q.cks[0]))
    else $error("manual reset changed control state");

  a_manual_keeps_cor: assert property (
    manual_rst && !standby && !wr_cor[0] |=> $stable(q.cor[0]))
    else $error("manual reset changed compare constant");

  a_standby_clears_cnt: assert property (
    standby |=> q.cnt[0] == `CNT_RST && q.cnt[1] == `CNT_RST)
    else $error("standby did not clear the counters");

endmodule : compare_match_timer
